// ===== verilog/lsu_defs.svh
// constants of the scalar load/store unit and register file
`ifndef LSU_DEFS_SVH
`define LSU_DEFS_SVH
`define LSU_OP_LD_A 8'h12
`define LSU_OP_LDX 8'h13
`define LSU_OP_SWP 8'h32
`define LSU_OP_LD_B 8'h5e
`define LSU_OP_ST_B 8'h5f
`define LSU_OP_LD_C 8'h7e
`define LSU_OP_ST_C 8'h7f
`define LSU_NUM_AREG 6
`define LSU_LONG_BUSY 17
`define LSU_LOAD_LAT 14
`define LSU_ST_GAP 2
`define LSU_ST_GROUP 3
`endif

// ===== verilog/lsu_pkg.sv
// types of the scalar load/store unit
package lsu_pkg;
  typedef enum logic [2:0] {
    LSU_K_LOAD = 3'b001,
    LSU_K_STORE = 3'b010,
    LSU_K_LONG = 3'b100
  } lsu_kind_t;
  typedef enum logic [2:0] {
    LSU_S_IDLE = 3'b001,
    LSU_S_GAP = 3'b010,
    LSU_S_LONG = 3'b100
  } lsu_state_t;
endpackage : lsu_pkg

// ===== verilog/lsu_regfile.sv
// 256 x 64 register file, two reads and two writes per cycle, registered read data
module lsu_regfile #(
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter int DW = 64
) (
  // clock
  input wire logic i_clk,
  // write ports
  input wire logic i_we0,
  input wire logic [AW-1:0] i_wa0,
  input wire logic [DW-1:0] i_wd0,
  input wire logic i_we1,
  input wire logic [AW-1:0] i_wa1,
  input wire logic [DW-1:0] i_wd1,
  // read ports
  input wire logic [AW-1:0] i_ra0,
  input wire logic [AW-1:0] i_ra1,
  output logic [DW-1:0] o_rd0,
  output logic [DW-1:0] o_rd1
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] next_rd0;
  logic [DW-1:0] next_rd1;
  // stored values only; bypass lives in the top
  always_comb begin
    next_rd0 = mem[i_ra0];
    next_rd1 = mem[i_ra1];
  end
  // port 1 wins if both write the same word
  always_ff @(posedge i_clk) begin
    if (i_we0) begin
      mem[i_wa0] <= i_wd0;
    end
    if (i_we1) begin
      mem[i_wa1] <= i_wd1;
    end
    o_rd0 <= next_rd0;
    o_rd1 <= next_rd1;
  end
endmodule : lsu_regfile

// ===== verilog/lsu_delay.sv
// fixed-length valid/data delay line carrying load results to write-back
module lsu_delay #(
  parameter int STAGES = 13,
  parameter int W = 72
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // input
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  // output
  output logic o_valid,
  output logic [W-1:0] o_data
);
  logic [STAGES-1:0] vld;
  logic [W-1:0] dat [STAGES];
  logic [STAGES-1:0] next_vld;
  logic [W-1:0] next_dat [STAGES];
  // one stage per cycle of memory latency
  always_comb begin
    next_vld[0] = i_valid;
    next_dat[0] = i_data;
  end
  for (genvar g = 1; g < STAGES; g++) begin : g_stage
    always_comb begin
      next_vld[g] = vld[g-1];
      next_dat[g] = dat[g-1];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      vld <= '0;
    end else begin
      vld <= next_vld;
    end
    dat <= next_dat;
  end
  assign o_valid = vld[STAGES-1];
  assign o_data = dat[STAGES-1];
endmodule : lsu_delay

// ===== verilog/lsu_unit.sv
// scalar load/store unit with its register file and result bypass
`include "lsu_defs.svh"
module lsu_unit #(
  parameter int AW = 8,
  parameter int DW = 64,
  parameter int NREG = `LSU_NUM_AREG
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // instruction issue
  input wire logic i_issue,
  input wire logic [7:0] i_opcode,
  input wire logic [AW-1:0] i_reg,
  input wire logic [47:0] i_addr,
  output logic o_busy,
  output logic o_illegal,
  // conflicts
  input wire logic i_mem_busy,
  input wire logic i_acc_int,
  input wire logic i_wbus_busy,
  // central memory
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [47:0] o_mem_addr,
  output logic [DW-1:0] o_mem_wdata,
  input wire logic [DW-1:0] i_mem_rdata,
  // scalar result write
  input wire logic i_sc_we,
  input wire logic [AW-1:0] i_sc_wa,
  input wire logic [DW-1:0] i_sc_wd,
  // exchange second write port
  input wire logic i_xw_we,
  input wire logic [AW-1:0] i_xw_wa,
  input wire logic [DW-1:0] i_xw_wd,
  // read ports
  input wire logic [AW-1:0] i_ra0,
  input wire logic [AW-1:0] i_ra1,
  output logic [DW-1:0] o_rd0,
  output logic [DW-1:0] o_rd1,
  // load completion
  output logic o_ld_done,
  output logic [AW-1:0] o_ld_reg
);
  import lsu_pkg::*;
  localparam int QW = 3 + AW + 48;
  localparam int CW = $clog2(`LSU_LONG_BUSY + 1);
  // queue of requests, one slot per address register
  logic [QW-1:0] q [NREG];
  logic [2:0] q_cnt;
  logic [2:0] used;
  logic [QW-1:0] next_q [NREG];
  logic [2:0] next_q_cnt;
  logic [2:0] next_used;
  lsu_state_t state;
  lsu_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [1:0] st_grp;
  logic [1:0] next_st_grp;
  logic next_busy;
  logic next_illegal;
  logic next_mem_req;
  logic next_mem_we;
  logic [47:0] next_mem_addr;
  logic [AW-1:0] next_rd_reg;
  logic rd_pend;
  logic next_rd_pend;
  lsu_kind_t in_kind;
  logic in_legal;
  logic [2:0] in_need;
  lsu_kind_t h_kind;
  logic go;
  logic [2:0] rel;
  logic [AW-1:0] rd_reg;
  logic wb_v;
  logic [AW+DW-1:0] wb_d;
  logic [AW+DW-1:0] pipe_d;
  logic [DW-1:0] rf_rd0;
  logic [DW-1:0] rf_rd1;
  logic [AW-1:0] ra0_d;
  logic [AW-1:0] ra1_d;
  logic fwd0;
  logic fwd1;
  logic [DW-1:0] next_rd0;
  logic [DW-1:0] next_rd1;
  logic wb_we;
  logic [AW-1:0] wb_wa;
  logic [DW-1:0] wb_wd;
  logic next_ld_done;
  logic [AW-1:0] next_ld_reg;

  always_comb begin
    in_legal = 1'b1;
    in_kind = LSU_K_LOAD;
    in_need = 3'd1;
    case (i_opcode)
      `LSU_OP_LD_A, `LSU_OP_LD_B, `LSU_OP_LD_C: begin
        in_kind = LSU_K_LOAD;
        in_need = 3'd1;
      end
      `LSU_OP_ST_B, `LSU_OP_ST_C: begin
        in_kind = LSU_K_STORE;
        in_need = 3'd2;
      end
      `LSU_OP_LDX, `LSU_OP_SWP: begin
        in_kind = LSU_K_LONG;
        in_need = 3'd2;
      end
      default: begin
        in_legal = 1'b0;
      end
    endcase
  end

  // head of queue launch decision
  always_comb begin
    h_kind = lsu_kind_t'(q[0][QW-1 -: 3]);
    go = (q_cnt != 3'd0) && (state == LSU_S_IDLE) && !i_mem_busy && !i_acc_int
      && !(i_wbus_busy && h_kind != LSU_K_STORE);
    rel = 3'd0;
    if (go && h_kind == LSU_K_LOAD) begin
      rel = 3'd1;
    end else if (state == LSU_S_GAP && cnt == '0) begin
      // store frees its pair after its gap
      rel = 3'd2;
    end else if (state == LSU_S_LONG && cnt == '0) begin
      // long ops free their pair after 17 cycles
      rel = 3'd2;
    end
  end

  // queue and timing sequencer next values
  always_comb begin
    next_q = q;
    next_q_cnt = q_cnt;
    next_used = used - rel;
    next_state = state;
    next_cnt = cnt;
    next_st_grp = st_grp;
    next_mem_req = 1'b0;
    next_mem_we = 1'b0;
    next_mem_addr = o_mem_addr;
    next_rd_reg = rd_reg;
    next_rd_pend = 1'b0;
    case (state)
      LSU_S_GAP: begin
        if (cnt == '0) begin
          next_state = LSU_S_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      LSU_S_LONG: begin
        if (cnt == '0) begin
          next_state = LSU_S_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
      end
    endcase
    // in-order service from the head slot
    if (go) begin
      for (int i = 0; i < NREG - 1; i++) begin
        next_q[i] = q[i+1];
      end
      next_q_cnt = q_cnt - 3'd1;
      next_mem_req = 1'b1;
      next_mem_addr = q[0][47:0];
      next_rd_reg = q[0][AW+47:48];
      case (h_kind)
        LSU_K_LOAD: begin
          next_rd_pend = 1'b1;
          next_st_grp = 2'd0;
        end
        LSU_K_STORE: begin
          // every third store adds one cycle
          next_mem_we = 1'b1;
          next_state = LSU_S_GAP;
          if (st_grp == 2'(`LSU_ST_GROUP - 1)) begin
            next_cnt = CW'(`LSU_ST_GAP - 1);
            next_st_grp = 2'd0;
          end else begin
            next_cnt = CW'(`LSU_ST_GAP - 2);
            next_st_grp = st_grp + 2'd1;
          end
        end
        default: begin
          next_rd_pend = 1'b1;
          next_state = LSU_S_LONG;
          next_cnt = CW'(`LSU_LONG_BUSY - 2);
          next_st_grp = 2'd0;
        end
      endcase
    end
    next_illegal = i_issue && !in_legal;
    // accept only when enough registers are free
    if (i_issue && in_legal && !o_busy) begin
      next_q[next_q_cnt] = {in_kind, i_reg, i_addr};
      next_q_cnt = next_q_cnt + 3'd1;
      next_used = next_used + in_need;
    end
    next_busy = (3'(NREG) - next_used) < 3'd2;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      q_cnt <= '0;
      used <= '0;
      state <= LSU_S_IDLE;
      cnt <= '0;
      st_grp <= '0;
      o_busy <= 1'b0;
      o_illegal <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= '0;
      rd_reg <= '0;
      rd_pend <= 1'b0;
    end else begin
      q_cnt <= next_q_cnt;
      used <= next_used;
      state <= next_state;
      cnt <= next_cnt;
      st_grp <= next_st_grp;
      o_busy <= next_busy;
      o_illegal <= next_illegal;
      o_mem_req <= next_mem_req;
      o_mem_we <= next_mem_we;
      o_mem_addr <= next_mem_addr;
      rd_reg <= next_rd_reg;
      rd_pend <= next_rd_pend;
    end
    q <= next_q;
  end

  // store data fetched through read port 1 the cycle before the request
  assign o_mem_wdata = o_rd1;

  // memory latency padded so the operand lands at issue+14
  lsu_delay #(
    .STAGES(`LSU_LOAD_LAT - 1),
    .W(AW + DW)
  ) u_delay (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_valid(rd_pend),
    .i_data({rd_reg, i_mem_rdata}),
    .o_valid(wb_v),
    .o_data(pipe_d)
  );
  assign wb_d = pipe_d;

  // scalar result owns the write bus; loads wait on bus busy instead
  always_comb begin
    wb_we = i_sc_we | wb_v;
    wb_wa = i_sc_we ? i_sc_wa : wb_d[AW+DW-1:DW];
    wb_wd = i_sc_we ? i_sc_wd : wb_d[DW-1:0];
    next_ld_done = wb_v && !i_sc_we;
    next_ld_reg = wb_d[AW+DW-1:DW];
  end

  // storage with dual read, dual write for exchange
  lsu_regfile #(
    .DEPTH(256),
    .AW(AW),
    .DW(DW)
  ) u_rf (
    .i_clk(i_clk),
    .i_we0(wb_we),
    .i_wa0(wb_wa),
    .i_wd0(wb_wd),
    .i_we1(i_xw_we),
    .i_wa1(i_xw_wa),
    .i_wd1(i_xw_wd),
    .i_ra0(i_ra0),
    .i_ra1(i_ra1),
    .o_rd0(rf_rd0),
    .o_rd1(rf_rd1)
  );

  // xor compare of read and pending scalar write address
  always_comb begin
    ra0_d = i_ra0 ^ i_sc_wa;
    ra1_d = i_ra1 ^ i_sc_wa;
    fwd0 = i_sc_we && (ra0_d == '0);
    fwd1 = i_sc_we && (ra1_d == '0);
    // bypass in the same cycle as the file write
    next_rd0 = fwd0 ? i_sc_wd : '0;
    next_rd1 = fwd1 ? i_sc_wd : '0;
  end

  // registered bypass choice matched to the registered file data
  logic fwd0_q;
  logic fwd1_q;
  logic [DW-1:0] byp0;
  logic [DW-1:0] byp1;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fwd0_q <= 1'b0;
      fwd1_q <= 1'b0;
      o_ld_done <= 1'b0;
      o_ld_reg <= '0;
    end else begin
      fwd0_q <= fwd0;
      fwd1_q <= fwd1;
      o_ld_done <= next_ld_done;
      o_ld_reg <= next_ld_reg;
    end
    byp0 <= next_rd0;
    byp1 <= next_rd1;
  end
  // outputs are the registered file word or the registered bypass word
  assign o_rd0 = fwd0_q ? byp0 : rf_rd0;
  assign o_rd1 = fwd1_q ? byp1 : rf_rd1;
endmodule : lsu_unit

// ===== bench/lsu_unit_properties.sv
// port-level checks of the load/store unit
module lsu_unit_props (
  // watched ports
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_issue,
  input wire logic [7:0] i_opcode,
  input wire logic o_busy,
  input wire logic o_illegal,
  input wire logic i_mem_busy,
  input wire logic i_acc_int,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic o_ld_done,
  input wire logic i_sc_we,
  input wire logic [7:0] i_sc_wa,
  input wire logic [63:0] i_sc_wd,
  input wire logic [7:0] i_ra0,
  input wire logic [7:0] i_ra1,
  input wire logic [63:0] o_rd0,
  input wire logic [63:0] o_rd1
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // own decode, so a wrong table in the design shows up
  wire legal = i_opcode inside {8'h12, 8'h13, 8'h32, 8'h5e, 8'h5f, 8'h7e, 8'h7f};
  AST_ILL: assert property (i_issue && !o_busy && !legal |=> o_illegal)
    else $error("illegal opcode not flagged");
  AST_LEG: assert property (i_issue && legal |=> !o_illegal)
    else $error("legal opcode flagged");
  AST_MBUSY: assert property (i_mem_busy |=> !o_mem_req)
    else $error("launch while memory busy");
  AST_ACCI: assert property (i_acc_int |=> !o_mem_req)
    else $error("launch during access interrupt");
  AST_STGAP: assert property (o_mem_req && o_mem_we |=> !(o_mem_req && o_mem_we))
    else $error("stores launched back to back");
  AST_LDLAT: assert property (o_mem_req && !o_mem_we |-> ##13 (i_sc_we or ##1 o_ld_done))
    else $error("load operand not written fourteen cycles after launch");
  AST_BYP0: assert property (i_sc_we && !(i_sc_wa ^ i_ra0) |=> o_rd0 == $past(i_sc_wd))
    else $error("read port 0 missed the scalar result");
  AST_BYP1: assert property (i_sc_we && !(i_sc_wa ^ i_ra1) |=> o_rd1 == $past(i_sc_wd))
    else $error("read port 1 missed the scalar result");
endmodule : lsu_unit_props

bind lsu_unit lsu_unit_props u_props (.*);

// ===== bench/lsu_mem_model.sv
// central memory stand-in: answers while the request stands
module lsu_mem_model (
  // request side
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [47:0] i_addr,
  // answer side
  output logic [63:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] last = 64'h0;
  // the unit takes the word at the edge that ends its request
  always @(posedge i_clk) if (i_req) last <= {16'ha5a5, i_addr};
  // released bus shows the inverse of the last answer so stale data never matches
  assign o_rdata = i_req ? {16'ha5a5, i_addr} : ~last;
endmodule : lsu_mem_model

// ===== bench/test_lsu_unit.sv
// self-checking bench for the scalar load/store unit
module test_lsu_unit;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_reset_n, i_issue, i_mem_busy, i_acc_int, i_wbus_busy;
  logic i_sc_we, i_xw_we, o_busy, o_illegal, o_mem_req, o_mem_we, o_ld_done;
  logic [7:0] i_opcode, i_reg, i_sc_wa, i_xw_wa, i_ra0, i_ra1, o_ld_reg, lr;
  logic [47:0] i_addr, o_mem_addr;
  logic [63:0] i_sc_wd, i_xw_wd, o_mem_wdata, i_mem_rdata, o_rd0, o_rd1, wd;
  int num_errors = 0, n_tests = 0, cyc = 0, n_req = 0, t_st = 0, t0 = 0, t_ld = 0;

  lsu_unit u_dut (.*);
  lsu_mem_model u_mem (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
    .o_rdata(i_mem_rdata));

  // 200 MHz clock
  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end
  // cycle count and launch log, sampled mid-cycle where outputs are settled
  always @(posedge i_clk) cyc <= cyc + 1;
  always @(negedge i_clk) begin
    if (o_mem_req === 1'b1) begin
      n_req++;
      if (o_mem_we === 1'b1) {t_st, wd} = {cyc, o_mem_wdata};
    end
    if (o_ld_done === 1'b1) {t_ld, lr} = {cyc, o_ld_reg};
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // request stays up until the taking edge has passed; busy drops it first
  task automatic iss(input logic [7:0] op, input logic [7:0] r);
    while (o_busy !== 1'b0) begin
      i_issue = 0;
      @(negedge i_clk);
    end
    i_issue = 1;
    i_opcode = op;
    i_reg = r;
    i_addr = {40'h0, r};
    @(negedge i_clk);
  endtask : iss

  task automatic t_ops;
    logic [7:0] ops [10] = '{8'h12, 8'h13, 8'h32, 8'h5e, 8'h5f, 8'h7e, 8'h7f, 8'h00, 8'h14, 8'hff};
    for (int k = 0; k < 10; k++) begin
      iss(ops[k], 8'h10);
      chk(o_illegal, k > 6);
      i_issue = 0;
      repeat (24) @(negedge i_clk);
    end
    $display("t_ops done");
  endtask : t_ops

  task automatic t_byp;
    {i_sc_we, i_sc_wa, i_sc_wd} = {1'b1, 8'hff, 64'h0123456789abcdef};
    {i_xw_we, i_xw_wa, i_xw_wd} = {1'b1, 8'h00, 64'hfedcba9876543210};
    {i_ra0, i_ra1} = 16'hffff;
    @(negedge i_clk);
    chk(o_rd0, 64'h0123456789abcdef);
    chk(o_rd1, 64'h0123456789abcdef);
    {i_sc_we, i_xw_we, i_ra0} = 10'h0;
    @(negedge i_clk);
    chk(o_rd0, 64'hfedcba9876543210);
    chk(o_rd1, 64'h0123456789abcdef);
    $display("t_byp done");
  endtask : t_byp

  task automatic t_load;
    t0 = cyc;
    for (int k = 0; k < 4; k++) iss(k[0] ? 8'h5e : 8'h7e, 8'h20 + 8'(k));
    i_issue = 0;
    {i_ra0, i_ra1} = 16'h2320;
    while (cyc < t0 + 20) @(negedge i_clk);
    @(negedge i_clk);
    chk(64'(t_ld - t0 - 1), 64'd18);
    chk(lr, 64'h23);
    chk(o_rd0, {16'ha5a5, 48'h23});
    chk(o_rd1, {16'ha5a5, 48'h20});
    $display("t_load done");
  endtask : t_load

  task automatic t_store;
    int r0;
    r0 = n_req;
    t0 = cyc;
    for (int k = 0; k < 4; k++) iss(k[0] ? 8'h7f : 8'h5f, 8'h20 + 8'(k));
    i_issue = 0;
    repeat (20) @(negedge i_clk);
    chk(64'(t_st - t0), 64'd9);
    chk(64'(n_req - r0), 64'd4);
    chk(wd, {16'ha5a5, 48'h20});
    $display("t_store done");
  endtask : t_store

  task automatic t_long;
    iss(8'h13, 8'h30);
    iss(8'h32, 8'h31);
    iss(8'h13, 8'h32);
    i_issue = 0;
    chk(o_busy, 1'b1);
    repeat (10) @(negedge i_clk);
    chk(o_busy, 1'b1);
    repeat (80) @(negedge i_clk);
    chk(o_busy, 1'b0);
    $display("t_long done");
  endtask : t_long

  task automatic t_stall;
    int r0;
    for (int k = 0; k < 3; k++) begin
      {i_wbus_busy, i_acc_int, i_mem_busy} = 3'(1 << k);
      iss(8'h12, 8'h40);
      i_issue = 0;
      r0 = n_req;
      repeat (8) @(negedge i_clk);
      chk(64'(n_req - r0), 64'd0);
      {i_wbus_busy, i_acc_int, i_mem_busy} = 3'h0;
      repeat (20) @(negedge i_clk);
      chk(64'(n_req - r0), 64'd1);
    end
    $display("t_stall done");
  endtask : t_stall

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // reset for three cycles, then the scenarios in turn
  initial begin
    {i_reset_n, i_issue, i_mem_busy, i_acc_int, i_wbus_busy, i_sc_we, i_xw_we} = '0;
    {i_opcode, i_reg, i_sc_wa, i_xw_wa, i_ra0, i_ra1} = '0;
    {i_addr, i_sc_wd, i_xw_wd} = '0;
    repeat (3) @(negedge i_clk);
    i_reset_n = 1;
    t_ops();
    t_byp();
    t_load();
    t_store();
    t_long();
    t_stall();
    finish_test();
  end
  // watchdog well past the expected run of about 480 cycles
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule : test_lsu_unit
